// file: logic/ect_timer.sv
// Function
// - all events share one masked interrupt
// - capture enable gates capture flag interrupts
// - compare enable gates compare flag interrupts
// - overflow enable gates overflow flag interrupt
// - force two drives level two pin
// - force one drives level one pin
// - compare two match copies level two in normal mode
// - edge one selects capture one edge
// - compare one match copies level one
// - pin one enable routes output and gates force one
// - pin two enable routes output and gates force two
// - single pulse triggered by capture pin
// - pwm: compare one width, two period
// - clock select picks prescale ratio
// - edge two selects capture two edge
// - capture one flag set, two-step clear
// - compare one flag set, two-step clear
// - overflow flag on wrap, counter clears
// - capture two flag set, two-step clear
// - compare two flag set, two-step clear
// - freeze stops counting, disables outputs
// - counter reads live, write reloads
//
// The register offsets and the Avalon-MM slave port were decided locally.
`timescale 1ns/1ns
`include "ect_defs.svh"
module ect_timer
  import ect_pkg::*;
#(
  parameter int OSC_DIV = `ECT_OSC_DIV
) (
  input wire logic i_clk, // cpu clock, 25 MHz
  input wire logic i_rst_n, // async reset, active low
  input wire logic [8:0] i_avs_address, // byte address
  input wire logic i_avs_read, // read request
  input wire logic i_avs_write, // write request
  input wire logic [31:0] i_avs_writedata, // write data, low byte used
  output logic [31:0] o_avs_readdata, // read data
  output logic o_avs_waitrequest, // high until answered
  input wire logic i_osc_tick, // oscillator-derived clock enable
  input wire logic i_first_capture_pin, // capture input one
  input wire logic i_second_capture_pin, // capture input two
  input wire logic i_irq_masked, // cpu interrupt mask set
  output logic o_irq, // timer interrupt request
  output logic o_first_compare_pin, // compare output one
  output logic o_first_compare_pin_oe, // compare one drives pin
  output logic o_second_compare_pin, // compare output two
  output logic o_second_compare_pin_oe // compare two drives pin
);
  // register index decode, used for every access
  function automatic logic is_idx(input logic [8:0] addr, input logic [6:0] idx);
    is_idx = (addr[8:2] == idx) && (addr[1:0] == 2'h0);
  endfunction : is_idx

  ect_tick_if tk ();

  // software registers
  ect_byte_t ctl_one_r; // timer_control_one
  ect_byte_t ctl_two_r; // timer_control_two
  logic freeze_r; // timer_freeze
  ect_byte_t cap1_r; // first_capture_value
  ect_byte_t cap2_r; // second_capture_value
  ect_byte_t cmp1_r; // first_compare_value
  ect_byte_t cmp2_r; // second_compare_value
  ect_byte_t cmp1_act_r; // compare one in use (pwm buffered)
  ect_byte_t cmp2_act_r; // compare two in use (pwm buffered)
  ect_byte_t cnt_r; // counter_value
  ect_byte_t cnt_nxt;
  logic [4:0] flags_r; // event flags
  logic [4:0] flags_nxt;
  logic [4:0] arm_r; // flags seen by a status read
  logic [4:0] arm_nxt;
  logic upd_r; // tick seen last cycle
  logic cap1_pin_r; // previous capture pin one
  logic cap2_pin_r; // previous capture pin two
  logic lvl1_r; // first pin level
  logic lvl1_nxt;
  logic lvl2_r; // second pin level
  logic lvl2_nxt;

  // bus and output flops
  logic wait_r; // waitrequest
  logic [31:0] rdata_r; // read data
  logic irq_r; // interrupt request
  logic oe1_r; // pin one enable
  logic oe2_r; // pin two enable

  // bus decode
  logic go; // access taken this cycle
  logic wr; // write taken
  logic rd; // read taken
  logic wr_ctl1, wr_ctl2, wr_csr, wr_cmp1, wr_cmp2, wr_cnt;
  logic rd_csr;
  logic acc_cap1, acc_cap2, acc_cmp1, acc_cmp2, acc_ctr;
  ect_byte_t rd_mux; // selected read byte
  ect_byte_t wbyte; // low write byte

  assign go = (i_avs_read | i_avs_write) & wait_r;
  assign wr = go & i_avs_write;
  assign rd = go & i_avs_read;
  assign wbyte = i_avs_writedata[7:0];
  assign wr_ctl1 = wr & is_idx(i_avs_address, `ECT_IDX_CR1);
  assign wr_ctl2 = wr & is_idx(i_avs_address, `ECT_IDX_CR2);
  assign wr_csr = wr & is_idx(i_avs_address, `ECT_IDX_CSR);
  assign wr_cmp1 = wr & is_idx(i_avs_address, `ECT_IDX_OC1);
  assign wr_cmp2 = wr & is_idx(i_avs_address, `ECT_IDX_OC2);
  assign wr_cnt = wr & (is_idx(i_avs_address, `ECT_IDX_CTR) |
                        is_idx(i_avs_address, `ECT_IDX_ALTERNATE_COUNTER_VALUE));
  assign rd_csr = rd & is_idx(i_avs_address, `ECT_IDX_CSR);
  // accesses that finish a two-step clear; the alternate counter never does
  assign acc_cap1 = go & is_idx(i_avs_address, `ECT_IDX_IC1);
  assign acc_cap2 = go & is_idx(i_avs_address, `ECT_IDX_IC2);
  assign acc_cmp1 = go & is_idx(i_avs_address, `ECT_IDX_OC1);
  assign acc_cmp2 = go & is_idx(i_avs_address, `ECT_IDX_OC2);
  assign acc_ctr = go & is_idx(i_avs_address, `ECT_IDX_CTR);

  // read multiplexer; unmapped reads return zero
  assign rd_mux =
    is_idx(i_avs_address, `ECT_IDX_CR2) ? (ctl_two_r & `ECT_CR2_WMASK) :
    is_idx(i_avs_address, `ECT_IDX_CR1) ? ctl_one_r :
    is_idx(i_avs_address, `ECT_IDX_CSR) ? {flags_r, freeze_r, 2'h0} :
    is_idx(i_avs_address, `ECT_IDX_IC1) ? cap1_r :
    is_idx(i_avs_address, `ECT_IDX_OC1) ? cmp1_r :
    (is_idx(i_avs_address, `ECT_IDX_CTR) |
     is_idx(i_avs_address, `ECT_IDX_ALTERNATE_COUNTER_VALUE)) ? cnt_r :
    is_idx(i_avs_address, `ECT_IDX_IC2) ? cap2_r :
    is_idx(i_avs_address, `ECT_IDX_OC2) ? cmp2_r : 8'h00;

  // mode decode; pwm wins when both mode bits are set
  ect_mode_t mode;
  logic pwm, pulse, run;
  assign pwm = ctl_two_r[`ECT_B_PWM];
  assign pulse = ctl_two_r[`ECT_B_ONE_PULSE] & ~pwm;
  assign mode = pwm ? ECT_MODE_PWM : (pulse ? ECT_MODE_PULSE : ECT_MODE_NORMAL);
  assign run = ~freeze_r;

  // prescaler link
  assign tk.clock_select = ctl_two_r[`ECT_B_CSEL_HI:`ECT_B_CSEL_LO];
  assign tk.timer_freeze = freeze_r;

  ect_prescale #(
    .OSC_DIV(OSC_DIV)
  ) u_presc (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_osc_tick(i_osc_tick),
    .tk(tk.presc)
  );

  // counter events
  logic tick, ovf, m1, m2, e1, e2, cap1_ev;
  assign tick = tk.tick & run;
  assign ovf = tick & (cnt_r == `ECT_CNT_TOP);
  assign m1 = upd_r & run & (cnt_r == cmp1_act_r);
  assign m2 = upd_r & run & (cnt_r == cmp2_act_r);
  assign e1 = run & (ctl_one_r[`ECT_B_EDGE1] ? (i_first_capture_pin & ~cap1_pin_r) :
                     (~i_first_capture_pin & cap1_pin_r));
  assign e2 = run & (ctl_two_r[`ECT_B_EDGE2] ? (i_second_capture_pin & ~cap2_pin_r) :
                     (~i_second_capture_pin & cap2_pin_r));
  assign cap1_ev = e1 & (mode != ECT_MODE_PWM); // pin one is cut off in pwm

  // next counter: write, mode reload, tick
  always_comb begin
    cnt_nxt = cnt_r;
    if (wr_cnt) begin
      cnt_nxt = `ECT_CNT_RST;
    end else if ((pulse & e1) | (pwm & m2)) begin
      cnt_nxt = `ECT_CNT_RST;
    end else if (tick) begin
      cnt_nxt = cnt_r + 8'h01;
    end
  end

  // flag set and two-step clear; a set in the clearing cycle wins
  logic [4:0] set_v, clr_v;
  assign set_v[`ECT_F_CAP1] = cap1_ev | (pwm & m2);
  assign set_v[`ECT_F_CMP1] = m1 & (mode == ECT_MODE_NORMAL);
  assign set_v[`ECT_F_OVF] = ovf;
  assign set_v[`ECT_F_CAP2] = e2;
  assign set_v[`ECT_F_CMP2] = m2 & ~pwm;
  assign clr_v[`ECT_F_CAP1] = acc_cap1 & arm_r[`ECT_F_CAP1];
  assign clr_v[`ECT_F_CMP1] = acc_cmp1 & arm_r[`ECT_F_CMP1];
  assign clr_v[`ECT_F_OVF] = acc_ctr & arm_r[`ECT_F_OVF];
  assign clr_v[`ECT_F_CAP2] = acc_cap2 & arm_r[`ECT_F_CAP2];
  assign clr_v[`ECT_F_CMP2] = acc_cmp2 & arm_r[`ECT_F_CMP2];
  assign flags_nxt = set_v | (flags_r & ~clr_v);
  assign arm_nxt = rd_csr ? flags_r : (arm_r & ~clr_v);

  // pin levels; compare logic runs whether or not pins are enabled
  logic force1, force2;
  assign force1 = ctl_one_r[`ECT_B_FORCE1] & ctl_two_r[`ECT_B_PIN1_EN];
  assign force2 = ctl_one_r[`ECT_B_FORCE2] & ctl_two_r[`ECT_B_PIN2_EN];
  always_comb begin
    lvl1_nxt = lvl1_r;
    if (force1) begin
      lvl1_nxt = ctl_one_r[`ECT_B_LVL1];
    end else if ((pulse & e1) | (pwm & m2)) begin
      lvl1_nxt = ctl_one_r[`ECT_B_LVL2];
    end else if (m1) begin
      lvl1_nxt = ctl_one_r[`ECT_B_LVL1];
    end
  end
  always_comb begin
    lvl2_nxt = lvl2_r;
    if (force2) begin
      lvl2_nxt = ctl_one_r[`ECT_B_LVL2];
    end else if (m2 & (mode == ECT_MODE_NORMAL)) begin
      lvl2_nxt = ctl_one_r[`ECT_B_LVL2];
    end
  end

  // interrupt source, one request for every event
  logic irq_nxt;
  assign irq_nxt = ~i_irq_masked & (
    (ctl_one_r[`ECT_B_CAP_IE] & (flags_r[`ECT_F_CAP1] | flags_r[`ECT_F_CAP2])) |
    (ctl_one_r[`ECT_B_CMP_IE] & (flags_r[`ECT_F_CMP1] | flags_r[`ECT_F_CMP2])) |
    (ctl_one_r[`ECT_B_OVF_IE] & flags_r[`ECT_F_OVF]));

  // bus slave: one wait cycle, then the answer
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wait_r <= 1'b1;
      rdata_r <= 32'h0000_0000;
    end else begin
      wait_r <= ~go;
      rdata_r <= rd ? {24'h00_0000, rd_mux} : 32'h0000_0000;
    end
  end

  // control registers; bit zero of control two is kept clear
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ctl_one_r <= `ECT_CR_RST;
      ctl_two_r <= `ECT_CR_RST;
      freeze_r <= 1'b0;
      cmp1_r <= `ECT_CR_RST;
      cmp2_r <= `ECT_CR_RST;
    end else begin
      if (wr_ctl1) ctl_one_r <= wbyte;
      if (wr_ctl2) ctl_two_r <= wbyte & `ECT_CR2_WMASK;
      if (wr_csr) freeze_r <= wbyte[`ECT_B_FREEZE];
      if (wr_cmp1) cmp1_r <= wbyte;
      if (wr_cmp2) cmp2_r <= wbyte;
    end
  end

  // compare values in use; pwm takes new values at period end
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cmp1_act_r <= `ECT_CR_RST;
      cmp2_act_r <= `ECT_CR_RST;
    end else if (~pwm | m2) begin
      cmp1_act_r <= cmp1_r;
      cmp2_act_r <= cmp2_r;
    end
  end

  // counter, flags and capture registers
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt_r <= `ECT_CNT_RST;
      upd_r <= 1'b0;
      flags_r <= `ECT_FLAGS_RST;
      arm_r <= `ECT_FLAGS_RST;
      cap1_r <= `ECT_CR_RST;
      cap2_r <= `ECT_CR_RST;
    end else begin
      cnt_r <= cnt_nxt;
      upd_r <= tick;
      flags_r <= flags_nxt;
      arm_r <= arm_nxt;
      if (cap1_ev) cap1_r <= cnt_r;
      if (e2) cap2_r <= cnt_r;
    end
  end

  // pin history, levels and registered outputs
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cap1_pin_r <= 1'b0;
      cap2_pin_r <= 1'b0;
      lvl1_r <= 1'b0;
      lvl2_r <= 1'b0;
      oe1_r <= 1'b0;
      oe2_r <= 1'b0;
      irq_r <= 1'b0;
    end else begin
      cap1_pin_r <= i_first_capture_pin;
      cap2_pin_r <= i_second_capture_pin;
      lvl1_r <= lvl1_nxt;
      lvl2_r <= lvl2_nxt;
      oe1_r <= ctl_two_r[`ECT_B_PIN1_EN] & run;
      oe2_r <= ctl_two_r[`ECT_B_PIN2_EN] & run;
      irq_r <= irq_nxt;
    end
  end

  assign o_avs_waitrequest = wait_r;
  assign o_avs_readdata = rdata_r;
  assign o_irq = irq_r;
  assign o_first_compare_pin = lvl1_r;
  assign o_first_compare_pin_oe = oe1_r;
  assign o_second_compare_pin = lvl2_r;
  assign o_second_compare_pin_oe = oe2_r;

  // checks
  property p_irq_mask;
    @(posedge i_clk) disable iff (!i_rst_n)
    $rose(o_irq) |-> $past(~i_irq_masked);
  endproperty
  a_irq_mask: assert property (p_irq_mask) else $error("irq while masked");

  property p_irq_cap;
    @(posedge i_clk) disable iff (!i_rst_n)
    (ctl_one_r[`ECT_B_CAP_IE] && flags_r[`ECT_F_CAP2] && !i_irq_masked) |=> o_irq;
  endproperty
  a_irq_cap: assert property (p_irq_cap) else $error("capture irq missing");

  property p_irq_ovf_off;
    @(posedge i_clk) disable iff (!i_rst_n)
    (!ctl_one_r[`ECT_B_OVF_IE] && !ctl_one_r[`ECT_B_CAP_IE] &&
     !ctl_one_r[`ECT_B_CMP_IE]) |=> !o_irq;
  endproperty
  a_irq_ovf_off: assert property (p_irq_ovf_off) else $error("irq with enables off");

  property p_wrap;
    @(posedge i_clk) disable iff (!i_rst_n)
    (tick && !wr_cnt && !(pulse && e1) && !(pwm && m2) && cnt_r == `ECT_CNT_TOP)
      |=> (cnt_r == 8'h00) && flags_r[`ECT_F_OVF];
  endproperty
  a_wrap: assert property (p_wrap) else $error("overflow not flagged");

  property p_cap2;
    @(posedge i_clk) disable iff (!i_rst_n)
    e2 |=> (cap2_r == $past(cnt_r)) && flags_r[`ECT_F_CAP2];
  endproperty
  a_cap2: assert property (p_cap2) else $error("capture two lost");

  property p_freeze;
    @(posedge i_clk) disable iff (!i_rst_n)
    (freeze_r && !wr_cnt) |=> $stable(cnt_r) ##1 (!o_first_compare_pin_oe || !freeze_r);
  endproperty
  a_freeze: assert property (p_freeze) else $error("frozen timer moved");

  property p_force2;
    @(posedge i_clk) disable iff (!i_rst_n)
    force2 |=> o_second_compare_pin == $past(ctl_one_r[`ECT_B_LVL2]);
  endproperty
  a_force2: assert property (p_force2) else $error("force two ignored");

  property p_cnt_write;
    @(posedge i_clk) disable iff (!i_rst_n)
    wr_cnt |=> (cnt_r == `ECT_CNT_RST) && !o_avs_waitrequest;
  endproperty
  a_cnt_write: assert property (p_cnt_write) else $error("counter not reloaded");

  property p_bus_answer;
    @(posedge i_clk) disable iff (!i_rst_n)
    go |=> !o_avs_waitrequest ##1 o_avs_waitrequest;
  endproperty
  a_bus_answer: assert property (p_bus_answer) else $error("bus answer late");
endmodule : ect_timer

// file: logic/ect_defs.svh
`ifndef ECT_DEFS_SVH
`define ECT_DEFS_SVH

// register indices; the byte address is four times the index
`define ECT_IDX_CR2 7'h3c
`define ECT_IDX_CR1 7'h3d
`define ECT_IDX_CSR 7'h3e
`define ECT_IDX_IC1 7'h3f
`define ECT_IDX_OC1 7'h40
`define ECT_IDX_CTR 7'h41
`define ECT_IDX_ALTERNATE_COUNTER_VALUE 7'h42
`define ECT_IDX_IC2 7'h43
`define ECT_IDX_OC2 7'h44

// timer_control_one fields
`define ECT_B_CAP_IE 7
`define ECT_B_CMP_IE 6
`define ECT_B_OVF_IE 5
`define ECT_B_FORCE2 4
`define ECT_B_FORCE1 3
`define ECT_B_LVL2 2
`define ECT_B_EDGE1 1
`define ECT_B_LVL1 0

// timer_control_two fields
`define ECT_B_PIN1_EN 7
`define ECT_B_PIN2_EN 6
`define ECT_B_ONE_PULSE 5
`define ECT_B_PWM 4
`define ECT_B_CSEL_HI 3
`define ECT_B_CSEL_LO 2
`define ECT_B_EDGE2 1
`define ECT_CR2_WMASK 8'hfe

// timer_flags_and_disable fields
`define ECT_B_FREEZE 2

// flag vector positions {cap1, cmp1, ovf, cap2, cmp2}
`define ECT_F_CAP1 4
`define ECT_F_CMP1 3
`define ECT_F_OVF 2
`define ECT_F_CAP2 1
`define ECT_F_CMP2 0

// reset and load values
`define ECT_CR_RST 8'h00
`define ECT_CNT_RST 8'hfc
`define ECT_CNT_TOP 8'hff
`define ECT_FLAGS_RST 5'h00

// prescaler divide ratios, stored as terminal count
`define ECT_CSEL_DIV4 2'h0
`define ECT_CSEL_DIV2 2'h1
`define ECT_CSEL_DIV8 2'h2
`define ECT_CSEL_OSC 2'h3
`define ECT_DIV4_TC 3'h3
`define ECT_DIV2_TC 3'h1
`define ECT_DIV8_TC 3'h7
`define ECT_OSC_DIV 8000

`endif

// file: logic/ect_pkg.sv
package ect_pkg;
  // operating mode, one-hot
  typedef enum logic [2:0] {
    ECT_MODE_NORMAL = 3'b001,
    ECT_MODE_PULSE = 3'b010,
    ECT_MODE_PWM = 3'b100
  } ect_mode_t;
  typedef logic [7:0] ect_byte_t;
endpackage : ect_pkg

// file: logic/ect_tick_if.sv
`timescale 1ns/1ns
interface ect_tick_if;
  logic [1:0] clock_select; // prescaler source select
  logic timer_freeze; // holds the prescaler
  logic tick; // one-cycle counting pulse
  modport timer (output clock_select, output timer_freeze, input tick);
  modport presc (input clock_select, input timer_freeze, output tick);
endinterface : ect_tick_if

// file: logic/ect_prescale.sv
`timescale 1ns/1ns
`include "ect_defs.svh"
module ect_prescale
  import ect_pkg::*;
#(
  parameter int OSC_DIV = `ECT_OSC_DIV
) (
  input wire logic i_clk, // cpu clock
  input wire logic i_rst_n, // async reset, active low
  input wire logic i_osc_tick, // oscillator-derived clock enable
  ect_tick_if.presc tk // select, freeze and tick
);
  localparam int CW = $clog2(OSC_DIV);

  // the osc divider must at least cover the widest cpu ratio
  if (OSC_DIV < 8) begin : g_chk
    $error("ect_prescale: OSC_DIV below 8");
  end

  logic [CW-1:0] div_r; // divider count
  logic [CW-1:0] div_nxt;
  logic tick_r; // registered tick
  logic [CW-1:0] tc; // terminal count of the chosen ratio
  logic step; // divider advances this cycle
  logic wrap; // divider reached its terminal count

  // ratio and step source from the clock select
  assign tc = (tk.clock_select == `ECT_CSEL_DIV4) ? CW'(`ECT_DIV4_TC) :
              (tk.clock_select == `ECT_CSEL_DIV2) ? CW'(`ECT_DIV2_TC) :
              (tk.clock_select == `ECT_CSEL_DIV8) ? CW'(`ECT_DIV8_TC) :
              CW'(OSC_DIV - 1);
  assign step = ~tk.timer_freeze &
                ((tk.clock_select != `ECT_CSEL_OSC) | i_osc_tick);
  assign wrap = step & (div_r >= tc);
  assign div_nxt = wrap ? '0 : (step ? div_r + CW'(1) : div_r);
  assign tk.tick = tick_r;

  // divider and tick flops
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      div_r <= '0;
      tick_r <= 1'b0;
    end else begin
      div_r <= div_nxt;
      tick_r <= wrap;
    end
  end
endmodule : ect_prescale

// file: test/testbench.sv
`timescale 1ns/1ns
`include "ect_defs.svh"
module testbench;
  localparam int OSC_DIV = 8; // short oscillator divide
  logic i_clk = 1'b0; // cpu clock
  logic i_rst_n = 1'b0; // reset, active low
  logic [8:0] avs_address = 9'h000; // bus address
  logic avs_read = 1'b0; // bus read
  logic avs_write = 1'b0; // bus write
  logic [31:0] avs_writedata = 32'h0; // bus write data
  logic osc_tick = 1'b0; // oscillator enable
  logic cap1 = 1'b0; // capture pin one
  logic cap2 = 1'b0; // capture pin two
  logic irq_masked = 1'b1; // cpu mask
  logic [31:0] avs_readdata; // bus read data
  logic avs_waitrequest; // bus stall
  logic irq, pin1, pin1_oe, pin2, pin2_oe; // timer outputs
  int fails = 0; // mismatch count
  int check_count = 0; // comparison count
  logic [31:0] rnd = 32'hbeb9b713; // random state
  int unsigned mdl [int]; // model of written registers
  logic [31:0] v; // last read value
  int delta, expt; // prescaler figures
  ect_timer #(.OSC_DIV(OSC_DIV)) i_ect_timer (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_avs_address(avs_address),
    .i_avs_read(avs_read), .i_avs_write(avs_write), .i_avs_writedata(avs_writedata),
    .o_avs_readdata(avs_readdata), .o_avs_waitrequest(avs_waitrequest),
    .i_osc_tick(osc_tick), .i_first_capture_pin(cap1), .i_second_capture_pin(cap2),
    .i_irq_masked(irq_masked), .o_irq(irq), .o_first_compare_pin(pin1),
    .o_first_compare_pin_oe(pin1_oe), .o_second_compare_pin(pin2),
    .o_second_compare_pin_oe(pin2_oe)
  );
  // free running clock
  always #20 i_clk = ~i_clk;
  // oscillator enable every other cycle
  always @(posedge i_clk) osc_tick <= ~osc_tick;
  // next random word
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr_next
  // compare and count
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  // one avalon transfer, held until waitrequest is seen low
  task automatic bus(input logic wr, input logic [6:0] idx, input logic [7:0] wd);
    int n;
    n = 0;
    rnd = lfsr_next(rnd);
    @(posedge i_clk);
    avs_address <= {idx, 2'b00};
    avs_write <= wr;
    avs_read <= ~wr;
    avs_writedata <= {rnd[31:8], wd};
    do begin
      @(posedge i_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    v = avs_readdata;
    if (n >= 50) fails++;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus
  // write and remember
  task automatic wr(input logic [6:0] idx, input logic [7:0] d);
    bus(1'b1, idx, d);
    mdl[idx] = d;
  endtask : wr
  // read and compare, upper bits must be zero
  task automatic rd_chk(input logic [6:0] idx, input logic [7:0] exp, input logic [7:0] m);
    bus(1'b0, idx, 8'h00);
    check({v[31:8], v[7:0] & m}, {24'h0, exp});
  endtask : rd_chk
  // idle cycles
  task automatic idle(input int n);
    repeat (n) @(posedge i_clk);
  endtask : idle
  // drive a capture pin after an edge
  task automatic set_pin(input int p, input logic lv);
    @(posedge i_clk);
    if (p == 0) cap1 <= lv;
    else cap2 <= lv;
    idle(4);
  endtask : set_pin
  // verdict and end of run
  task automatic wrap_up();
    if (fails == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : wrap_up
  // watchdog against a hang
  initial begin
    repeat (20000) @(posedge i_clk);
    fails++;
    wrap_up();
  end
  // main sequence
  initial begin
    repeat (10) @(posedge i_clk);
    i_rst_n <= 1'b1;
    // freeze at once so no tick lands, then reset values of every register
    mdl.delete();
    wr(`ECT_IDX_CSR, 8'h04);
    for (int k = 'h3c; k <= 'h44; k++) begin
      rd_chk(7'(k), (k == 'h3e) ? 8'h04 :
             ((k == 'h41 || k == 'h42) ? `ECT_CNT_RST : 8'h00), 8'hff);
    end
    check({irq, pin1_oe, pin2_oe}, 3'b000);
    // freeze holds the counter, writes reload it
    wr(`ECT_IDX_CSR, 8'h04);
    wr(`ECT_IDX_ALTERNATE_COUNTER_VALUE, 8'h55);
    rd_chk(`ECT_IDX_CTR, `ECT_CNT_RST, 8'hff);
    idle(20);
    rd_chk(`ECT_IDX_ALTERNATE_COUNTER_VALUE, `ECT_CNT_RST, 8'hff);
    // random readback, unmapped index and read-only flags
    for (int i = 0; i < 6; i++) begin
      rnd = lfsr_next(rnd);
      wr(`ECT_IDX_CR1, rnd[7:0]);
      wr(`ECT_IDX_CR2, rnd[15:8] & `ECT_CR2_WMASK);
      wr(`ECT_IDX_OC1, rnd[23:16]);
      wr(`ECT_IDX_CSR, rnd[31:24] | 8'h04);
      rd_chk(`ECT_IDX_CR1, 8'(mdl[`ECT_IDX_CR1]), 8'hff);
      rd_chk(`ECT_IDX_CR2, 8'(mdl[`ECT_IDX_CR2]) & `ECT_CR2_WMASK, 8'hff);
      rd_chk(`ECT_IDX_OC1, 8'(mdl[`ECT_IDX_OC1]), 8'hff);
      rd_chk(`ECT_IDX_CSR, 8'h04, 8'hff);
      wr(7'h45, rnd[7:0]);
      rd_chk(7'h45, 8'h00, 8'hff);
    end
    wr(`ECT_IDX_CR1, 8'h00);
    wr(`ECT_IDX_OC1, 8'h80);
    wr(`ECT_IDX_OC2, 8'h80);
    // every clock select: ticks over a fixed unfrozen span
    for (int cs = 0; cs < 4; cs++) begin
      wr(`ECT_IDX_CTR, 8'h00);
      wr(`ECT_IDX_CR2, 8'(cs << 2));
      wr(`ECT_IDX_CSR, 8'h00);
      idle(64);
      wr(`ECT_IDX_CSR, 8'h04);
      bus(1'b0, `ECT_IDX_CTR, 8'h00);
      delta = int'(8'(v[7:0] - `ECT_CNT_RST));
      expt = 66 / ((cs == 0) ? 4 : (cs == 1) ? 2 : (cs == 2) ? 8 : 2 * OSC_DIV);
      check(32'(delta + 1 >= expt && delta <= expt + 1), 32'h1);
    end
    // overflow flag, alternate counter does not clear it
    bus(1'b0, `ECT_IDX_CSR, 8'h00);
    bus(1'b0, `ECT_IDX_CTR, 8'h00);
    rd_chk(`ECT_IDX_CSR, 8'h04, 8'hff);
    wr(`ECT_IDX_CR2, 8'h04);
    wr(`ECT_IDX_CTR, 8'h00);
    wr(`ECT_IDX_CSR, 8'h00);
    idle(20);
    wr(`ECT_IDX_CSR, 8'h04);
    rd_chk(`ECT_IDX_CSR, 8'h24, 8'hff);
    bus(1'b0, `ECT_IDX_ALTERNATE_COUNTER_VALUE, 8'h00);
    rd_chk(`ECT_IDX_CSR, 8'h24, 8'hff);
    // overflow interrupt gated by enable and mask
    wr(`ECT_IDX_CR1, 8'h20);
    irq_masked <= 1'b0;
    idle(3);
    check(irq, 1'b1);
    irq_masked <= 1'b1;
    idle(3);
    check(irq, 1'b0);
    irq_masked <= 1'b0;
    wr(`ECT_IDX_CR1, 8'h00);
    idle(3);
    check(irq, 1'b0);
    bus(1'b1, `ECT_IDX_CTR, 8'h00);
    rd_chk(`ECT_IDX_CSR, 8'h04, 8'hff);
    // captures on both pins, both edge selections
    wr(`ECT_IDX_CSR, 8'h00);
    for (int p = 0; p < 2; p++) begin
      for (int e = 0; e < 2; e++) begin
        wr(`ECT_IDX_CR1, 8'h80 | ((p == 0) ? 8'(e << 1) : 8'h00));
        wr(`ECT_IDX_CR2, 8'h08 | ((p == 1) ? 8'(e << 1) : 8'h00));
        set_pin(p, 1'(e));
        bus(1'b0, `ECT_IDX_CSR, 8'h00);
        bus(1'b0, (p == 0) ? `ECT_IDX_IC1 : `ECT_IDX_IC2, 8'h00);
        set_pin(p, 1'(!e));
        rd_chk(`ECT_IDX_CSR, 8'h00, (p == 0) ? 8'h80 : 8'h10);
        check(irq, 1'b0);
        set_pin(p, 1'(e));
        rd_chk(`ECT_IDX_CSR, (p == 0) ? 8'h80 : 8'h10, 8'h90);
        check(irq, 1'b1);
        bus(1'b1, (p == 0) ? `ECT_IDX_IC1 : `ECT_IDX_IC2, 8'h00);
        rd_chk(`ECT_IDX_CSR, 8'h00, 8'h90);
      end
    end
    // forced levels on enabled pins
    wr(`ECT_IDX_CR1, 8'h00);
    wr(`ECT_IDX_CR2, 8'hc4);
    wr(`ECT_IDX_CR1, 8'h1d);
    idle(4);
    check({pin1, pin1_oe, pin2, pin2_oe}, 4'b1111);
    wr(`ECT_IDX_CR1, 8'h18);
    idle(4);
    check({pin1, pin2}, 2'b00);
    // matches copy the levels and raise both compare flags
    wr(`ECT_IDX_OC1, 8'h10);
    wr(`ECT_IDX_OC2, 8'h20);
    wr(`ECT_IDX_CR1, 8'h45);
    idle(600);
    check({pin1, pin2}, 2'b11);
    wr(`ECT_IDX_CR2, 8'h04);
    idle(3);
    check({pin1_oe, pin2_oe}, 2'b00);
    wr(`ECT_IDX_CR2, 8'hc4);
    wr(`ECT_IDX_CSR, 8'h04);
    idle(3);
    check({pin1_oe, pin2_oe}, 2'b00);
    check(irq, 1'b1);
    rd_chk(`ECT_IDX_CSR, 8'h4c, 8'h4c);
    bus(1'b0, `ECT_IDX_OC1, 8'h00);
    rd_chk(`ECT_IDX_CSR, 8'h0c, 8'h4c);
    bus(1'b1, `ECT_IDX_OC2, 8'h20);
    rd_chk(`ECT_IDX_CSR, 8'h04, 8'h4c);
    idle(3);
    check(irq, 1'b0);
    // pwm: compare one sets the high time, compare two the period
    wr(`ECT_IDX_CR1, 8'h04);
    wr(`ECT_IDX_CR2, 8'h94);
    wr(`ECT_IDX_CTR, 8'h00);
    wr(`ECT_IDX_CSR, 8'h00);
    delta = 0;
    repeat (360) begin
      @(posedge i_clk);
      delta += int'(pin1);
    end
    expt = 360 * int'(8'(8'h10 - `ECT_CNT_RST)) / int'(8'(8'h20 - `ECT_CNT_RST));
    check(32'(delta >= expt - 50 && delta <= expt + 50), 32'h1);
    rd_chk(`ECT_IDX_CSR, 8'h80, 8'hc8);
    // one pulse: pin forced low first, then a rising edge starts the pulse
    wr(`ECT_IDX_CSR, 8'h04);
    wr(`ECT_IDX_CR2, 8'ha4);
    wr(`ECT_IDX_CR1, 8'h0e);
    wr(`ECT_IDX_CR1, 8'h06);
    wr(`ECT_IDX_CTR, 8'h00);
    wr(`ECT_IDX_CSR, 8'h00);
    set_pin(0, 1'b0);
    check(pin1, 1'b0);
    set_pin(0, 1'b1);
    check(pin1, 1'b1);
    idle(100);
    check(pin1, 1'b0);
    wrap_up();
  end
endmodule : testbench
